// file: include/lp4_host_defines.svh
// Register map, command/address codes and timing counts for the command host.
// Assumes a 20 MHz ref_clk that also clocks the device command bus.
`ifndef LP4_HOST_DEFINES_SVH
`define LP4_HOST_DEFINES_SVH

`define REG_CTRL     8'h00
`define REG_ADDR     8'h04
`define REG_CMD      8'h08
`define REG_STATUS   8'h0C
`define REG_BANKS    8'h10
`define CTRL_OTF_BIT 0
`define CTRL_BL_BIT  1
`define CTRL_RESET   2'h0
`define STAT_ERR_BIT 1
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// Low five command/address lines of each first cycle, low two for activate; the higher bits carry fields.
`define CA_MPC1      5'h00
`define CA_PRE1      5'h10
`define CA_REF1      5'h08
`define CA_SRE1      5'h18
`define CA_WR1       5'h04
`define CA_SRX1      5'h14
`define CA_MWR1      5'h0C
`define CA_RD1       5'h02
`define CA_CAS1      5'h12
`define CA_MRW1      5'h06
`define CA_MRW2      5'h16
`define CA_MRR1      5'h0E
`define CA_ACT1      2'h1
`define CA_ACT2      2'h3

`define CLK_MHZ      20
`define NS2CYC(t)    ((((t) * `CLK_MHZ) + 999) / 1000)
`define T_RP_NS      18
`define T_RCD_NS     18
`define T_RFCAB_NS   280
`define T_RFCPB_NS   140
`define T_MRW_NS     10
`define T_XP_NS      8
`define T_RP_CYC     `NS2CYC(`T_RP_NS)
`define T_RCD_CYC    `NS2CYC(`T_RCD_NS)
`define T_RFCAB_CYC  `NS2CYC(`T_RFCAB_NS)
`define T_RFCPB_CYC  `NS2CYC(`T_RFCPB_NS)
`define T_MRW_CYC    `NS2CYC(`T_MRW_NS)
`define T_XP_CYC     `NS2CYC(`T_XP_NS)
`define T_MRR_CYC    8
`define BURST16_CYC  8
`define RW_LAT_CYC   16
`define MPC_GAP_CYC  2

`endif

// file: include/lp4_host_pkg.sv
// Types shared by the command host and its bench.
// Assumes lp4_host_defines.svh for all numeric constants.
package lp4_host_pkg;

	typedef enum logic [3:0]
	{
		OP_NONE = 4'h0, OP_ACT = 4'h1, OP_RD = 4'h2, OP_WR = 4'h3,
		OP_MWR = 4'h4, OP_PRE = 4'h5, OP_REF = 4'h6, OP_MRW = 4'h7,
		OP_MRR = 4'h8, OP_MPC = 4'h9, OP_MPC_NC = 4'hA, OP_SRE = 4'hB,
		OP_SRX = 4'hC, OP_PDE = 4'hD, OP_PDX = 4'hE
	} op_type;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0, ST_ISSUE = 3'h1, ST_GAP = 3'h2, ST_CKE = 3'h3, ST_XP = 3'h4
	} seq_state_type;

	typedef enum logic [2:0]
	{
		BK_IDLE = 3'h0, BK_ACTIVATING = 3'h1, BK_ACTIVE = 3'h2, BK_READING = 3'h3,
		BK_WRITING = 3'h4, BK_PRECHARGING = 3'h5, BK_REFRESHING = 3'h6
	} bank_state_type;

	typedef enum logic [1:0]
	{
		PW_ACTIVE = 2'h0, PW_PD = 2'h1, PW_SR = 2'h2, PW_SRPD = 2'h3
	} pwr_type;

endpackage

// file: sim/lp4_dev_model.sv
// Device model on the command pins: decodes words, tracks open banks,
// counts protocol violations. Assumes it shares ref_clk with the host.
`timescale 1ns/100ps
`default_nettype none
`include "lp4_host_defines.svh"
module lp4_dev_model
(
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// Command pins.
	input  wire logic       dram_cke,
	input  wire logic       dram_cs,
	input  wire logic [5:0] dram_ca,
	// Observed state.
	output logic [7:0]      open_mask,
	output int              n_viol
);
	logic       cke_r;
	logic       second_r;
	logic       sr_r;
	logic [5:0] first_r;
	logic [1:0] need_r;
	logic [1:0] des_r;
	always @(posedge ref_clk or negedge reset_n)
	if (!reset_n)
	begin
		{second_r, sr_r, first_r, need_r, des_r, open_mask, n_viol} <= '0;
		cke_r <= 1'b1;
	end
	else
	begin
		cke_r <= dram_cke;
		if (dram_cs && (dram_cke != cke_r || !dram_cke || des_r != 2'h0))
			n_viol <= n_viol + 1;
		des_r <= (dram_cke && !cke_r) ? 2'h2 : des_r - {1'b0, des_r != 2'h0};
		if (second_r)
		begin
			second_r <= 1'b0;
			if (dram_cs)
				n_viol <= n_viol + 1;
			if (first_r[1:0] == `CA_ACT1)
				open_mask[dram_ca[2:0]] <= 1'b1;
			if (first_r[4:0] == `CA_PRE1)
				open_mask <= first_r[5] ? 8'h00 : open_mask & ~(8'h01 << dram_ca[2:0]);
			if (first_r[4:0] == `CA_SRE1 || first_r[4:0] == `CA_SRX1)
				sr_r <= first_r[4:0] == `CA_SRE1;
		end
		else if (dram_cs)
		begin
			second_r <= 1'b1;
			first_r <= dram_ca;
			if ((need_r == 2'h1 && dram_ca[1:0] != `CA_ACT2)
				|| (need_r == 2'h2 && dram_ca[4:0] != `CA_CAS1)
				|| (need_r == 2'h3 && dram_ca[4:0] != `CA_MRW2)
				|| (dram_ca[4:0] == `CA_MWR1 && dram_ca[5])
				|| (sr_r && !(dram_ca[4:0] inside {`CA_MPC1, `CA_MRW1, `CA_MRW2,
				`CA_MRR1, `CA_CAS1, `CA_SRX1})))
				n_viol <= n_viol + 1;
			need_r <= dram_ca[1:0] == `CA_ACT1 ? 2'h1 : dram_ca[4:0] == `CA_MRW1 ? 2'h3
				: dram_ca[4:0] inside {`CA_RD1, `CA_WR1, `CA_MWR1, `CA_MRR1} ? 2'h2 : 2'h0;
		end
		else if (need_r != 2'h0)
			n_viol <= n_viol + 1;
	end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the command host: AXI4-Lite orders in,
// command pins watched by the device model. Assumes package and defines.
`timescale 1ns/100ps
`default_nettype none
`include "lp4_host_defines.svh"
module testbench;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        dram_cke;
	logic        dram_cs;
	logic [5:0]  dram_ca;
	logic [7:0]  open_mask;
	int          n_viol;
	logic [5:0]  first_ca = 6'h00;
	logic        cs_d1 = 1'b0;
	logic        cs_d2 = 1'b0;
	int          n_mismatch = 0;
	int          n_compared = 0;
	always #25 ref_clk = ~ref_clk;
	lp4_cmd_host u_dut (.ref_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .dram_cke, .dram_cs, .dram_ca);
	lp4_dev_model u_dev (.ref_clk, .reset_n, .dram_cke, .dram_cs, .dram_ca, .open_mask,
		.n_viol);
	// Keeps the first pin word of the latest order for field checks.
	// A command's later first-cycle word comes two cycles after its first, so it is skipped.
	always @(posedge ref_clk)
	begin
		cs_d1 <= dram_cs;
		cs_d2 <= cs_d1;
		if (dram_cs && !cs_d2)
			first_ca <= dram_ca;
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge ref_clk);
			if (awready && !aw_done)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (!bvalid);
		r = bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string what);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		cmp(what, e, d & m);
	endtask
	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		cmp("write response", `RESP_OKAY, r);
	endtask
	// The busy flag rises on the same edge as the response; four cycles pass before the status poll starts.
	task automatic do_cmd(input logic [31:0] c);
		logic [31:0] d;
		logic [1:0]  r;
		wr_ok(`REG_CMD, c);
		repeat (4) @(posedge ref_clk);
		d = 32'h1;
		while (d[0])
			axi_rd(`REG_STATUS, d, r);
	endtask
	task automatic wait_banks(input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 40; i++)
			if (i == 0 || d !== e)
				axi_rd(`REG_BANKS, d, r);
		cmp("bank states", e, d & 32'hFFFFFF);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rd_chk(`REG_STATUS, 32'hFF3F, 32'h0020, "status after reset");
		rd_chk(`REG_BANKS, 32'hFFFFFF, 32'h0, "banks after reset");
		axi_rd(8'h14, d, r);
		cmp("unmapped read", `RESP_SLVERR, r);
		axi_wr(8'h14, 32'h1, r);
		cmp("unmapped write", `RESP_SLVERR, r);
	endtask
	task automatic t_access();
		do_cmd(32'h031);
		cmp("activate code", `CA_ACT1, first_ca[1:0]);
		wait_banks(32'h400);
		wr_ok(`REG_CTRL, 32'h2);
		do_cmd(32'h033);
		cmp("write word, fixed burst", 6'h24, first_ca);
		wr_ok(`REG_CTRL, 32'h1);
		do_cmd(32'h332);
		cmp("read word, burst 32", 6'h22, first_ca);
		wait_banks(32'h0);
	endtask
	task automatic t_mask_pre();
		do_cmd(32'h011);
		do_cmd(32'h051);
		wait_banks(32'h10010);
		do_cmd(32'h214);
		cmp("mask write word", 6'h0C, first_ca);
		do_cmd(32'h085);
		wait_banks(32'h0);
		cmp("model open banks", 8'h00, open_mask);
	endtask
	task automatic t_mode();
		wr_ok(`REG_ADDR, 32'hA50D);
		do_cmd(32'h007);
		cmp("mode write word", 6'h26, first_ca);
		rd_chk(`REG_STATUS, 32'h3, 32'h0, "mode write taken");
		wr_ok(`REG_ADDR, 32'h0043);
		do_cmd(32'h009);
		cmp("multipurpose word", 6'h20, first_ca);
		wr_ok(`REG_ADDR, 32'h0005);
		do_cmd(32'h00A);
		cmp("oscillator word", 6'h00, first_ca);
		rd_chk(`REG_STATUS, 32'h3, 32'h0, "multipurpose done");
	endtask
	task automatic t_power();
		do_cmd(32'h021);
		do_cmd(32'h086);
		rd_chk(`REG_STATUS, 32'h2, 32'h2, "refresh with open bank");
		wr_ok(`REG_STATUS, 32'h2);
		do_cmd(32'h00D);
		rd_chk(`REG_STATUS, 32'h3C, 32'h14, "active power-down");
		do_cmd(32'h00E);
		rd_chk(`REG_STATUS, 32'h2C, 32'h20, "power-down exit");
		wait_banks(32'h80);
		do_cmd(32'h025);
		do_cmd(32'h00B);
		do_cmd(32'h00D);
		rd_chk(`REG_STATUS, 32'h2C, 32'h0C, "self refresh power-down");
		do_cmd(32'h00E);
		do_cmd(32'h008);
		do_cmd(32'h001);
		rd_chk(`REG_STATUS, 32'h2E, 32'h2A, "activate in self refresh");
		wait_banks(32'h0);
		do_cmd(32'h00C);
		rd_chk(`REG_STATUS, 32'h2C, 32'h20, "self refresh exit");
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_access();
		t_mask_pre();
		t_mode();
		t_power();
		cmp("pin protocol violations", 32'h0, n_viol);
		end_sim();
	end
endmodule
`default_nettype wire

// file: src/lp4_cmd_host.sv
// Command host for one channel of a low-power DDR4 device: takes orders over
// AXI4-Lite, sequences two-part commands, clock enable and bank timing.
// Assumes ref_clk also clocks the device command bus and runs free.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "lp4_host_defines.svh"

module lp4_cmd_host
	import lp4_host_pkg::*;
#(
	parameter int NUM_BANKS = 8
)
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// AXI4-Lite write channels.
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Device command pins.
	output logic             dram_cke,
	output logic             dram_cs,
	output logic [5:0]       dram_ca
);

	logic                awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic                aw_ok_r, w_ok_r;
	logic [1:0]          bresp_r, rresp_r;
	logic [31:0]         rdata_r, wdata_r;
	logic [7:0]          awaddr_r;
	logic [3:0]          wstrb_r;
	logic [1:0]          ctrl_r;
	logic [15:0]         addr_r;
	op_type              op_r;
	logic [2:0]          bank_r;
	logic                ab_r, ap_r, bl_r, pend_r, err_r, pd_act_r, cke_r, cs_r;
	logic [5:0]          ca_r;
	seq_state_type       st_r, st_nxt;
	logic [1:0]          step_r, step_nxt;
	logic [7:0]          cnt_r, cnt_nxt, blk_tmr_r, burst_tmr_r;
	pwr_type             pwr_r, pwr_nxt;
	bank_state_type      bank_st_r [NUM_BANKS];
	logic [7:0]          bank_tmr_r [NUM_BANKS];
	logic                bank_ap_r [NUM_BANKS];
	logic [NUM_BANKS-1:0] idle_v, settled_v;
	logic [23:0]         bank_vec;
	logic [6:0]          seq_w [4];
	logic [1:0]          last_c;
	logic                wait_c, ok_c, drop_c, done_c, cke_nxt;

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign dram_cke = cke_r;
	assign dram_cs = cs_r;
	assign dram_ca = ca_r;

	// Register decode.
	wire wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
	wire sel_ctrl = awaddr_r == `REG_CTRL;
	wire sel_addr = awaddr_r == `REG_ADDR;
	wire sel_cmd = awaddr_r == `REG_CMD;
	wire sel_stat = awaddr_r == `REG_STATUS;
	wire wr_map = sel_ctrl || sel_addr || sel_cmd || sel_stat;
	wire cmd_wr = wr_fire && sel_cmd && wstrb_r[0];
	wire cmd_take = cmd_wr && !pend_r;
	wire err_clr = wr_fire && sel_stat && wstrb_r[0] && wdata_r[`STAT_ERR_BIT];
	wire [31:0] status_c = {16'h0000, ~idle_v, 2'h0, cke_r, pd_act_r, pwr_r, err_r, pend_r};
	wire [31:0] cmd_rd_c = {22'h000000, bl_r, ap_r, ab_r, bank_r, op_r};
	wire rd_map = araddr == `REG_CTRL || araddr == `REG_ADDR || araddr == `REG_CMD
		|| araddr == `REG_STATUS || araddr == `REG_BANKS;
	wire [31:0] rd_mux_c = (araddr == `REG_CTRL) ? {30'h00000000, ctrl_r} :
		(araddr == `REG_ADDR) ? {16'h0000, addr_r} :
		(araddr == `REG_CMD) ? cmd_rd_c :
		(araddr == `REG_STATUS) ? status_c :
		(araddr == `REG_BANKS) ? {8'h00, bank_vec} : 32'h00000000;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (awvalid && awready_r)
			begin
				awaddr_r <= awaddr;
				aw_ok_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (wvalid && wready_r)
			begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
				w_ok_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
			end
			if (bvalid_r && bready)
			begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end
		else if (arvalid && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux_c;
			rresp_r <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid_r && rready)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Orders: a command write while one is pending is refused and flagged.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_r <= `CTRL_RESET;
			addr_r <= 16'h0000;
			op_r <= OP_NONE;
			bank_r <= 3'h0;
			ab_r <= 1'b0;
			ap_r <= 1'b0;
			bl_r <= 1'b0;
			pend_r <= 1'b0;
			err_r <= 1'b0;
		end
		else
		begin
			if (wr_fire && sel_ctrl && wstrb_r[0])
				ctrl_r <= wdata_r[1:0];
			if (wr_fire && sel_addr && wstrb_r[0])
				addr_r[7:0] <= wdata_r[7:0];
			if (wr_fire && sel_addr && wstrb_r[1])
				addr_r[15:8] <= wdata_r[15:8];
			if (cmd_take)
			begin
				op_r <= op_type'(wdata_r[3:0]);
				bank_r <= wdata_r[6:4];
				ab_r <= wdata_r[7];
				ap_r <= wdata_r[8];
				bl_r <= wdata_r[9];
			end
			pend_r <= cmd_take || (pend_r && !done_c && !drop_c);
			// A new fault in the clearing cycle wins over the clear.
			err_r <= (cmd_wr && pend_r) || drop_c || (err_r && !err_clr);
		end
	end

	// Per-bank state and timers.
	wire go = st_r == ST_ISSUE && step_r == 2'h0;
	wire is_rw = op_r == OP_RD || op_r == OP_WR || op_r == OP_MWR;
	wire ab_eff = ab_r && (op_r == OP_PRE || op_r == OP_REF);
	wire bank_op = op_r == OP_ACT || is_rw || op_r == OP_PRE || op_r == OP_REF;
	wire bl32 = op_r != OP_MWR && (ctrl_r[`CTRL_OTF_BIT] ? bl_r : ctrl_r[`CTRL_BL_BIT]);
	wire bl_pin = op_r != OP_MWR && (ctrl_r[`CTRL_OTF_BIT] ? bl_r : ctrl_r[`CTRL_BL_BIT]);
	wire [7:0] burst_c = bl32 ? 8'(`RW_LAT_CYC + 2 * `BURST16_CYC) : 8'(`RW_LAT_CYC + `BURST16_CYC);
	wire all_idle = &idle_v;
	wire all_settled = &settled_v;

	for (genvar g = 0; g < NUM_BANKS; g++)
	begin : bank_g
		wire hit = go && bank_op && (ab_eff || bank_r == 3'(g));
		wire busy = bank_tmr_r[g] != 8'h00;
		assign idle_v[g] = bank_st_r[g] == BK_IDLE;
		assign settled_v[g] = idle_v[g] || bank_st_r[g] == BK_ACTIVE;
		assign bank_vec[3*g +: 3] = bank_st_r[g];
		always_ff @(posedge ref_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				bank_st_r[g] <= BK_IDLE;
				bank_tmr_r[g] <= 8'h00;
				bank_ap_r[g] <= 1'b0;
			end
			else if (hit)
			begin
				bank_ap_r[g] <= ap_r && is_rw;
				bank_st_r[g] <= op_r == OP_ACT ? BK_ACTIVATING : op_r == OP_RD ? BK_READING :
					is_rw ? BK_WRITING : op_r == OP_PRE ? BK_PRECHARGING : BK_REFRESHING;
				bank_tmr_r[g] <= op_r == OP_ACT ? 8'(`T_RCD_CYC) : is_rw ? burst_c :
					op_r == OP_PRE ? 8'(`T_RP_CYC) :
					ab_r ? 8'(`T_RFCAB_CYC) : 8'(`T_RFCPB_CYC);
			end
			else if (busy)
				bank_tmr_r[g] <= bank_tmr_r[g] - 8'h01;
			else if (bank_st_r[g] == BK_READING || bank_st_r[g] == BK_WRITING)
			begin
				bank_st_r[g] <= bank_ap_r[g] ? BK_PRECHARGING : BK_ACTIVE;
				bank_tmr_r[g] <= bank_ap_r[g] ? 8'(`T_RP_CYC) : 8'h00;
			end
			else if (bank_st_r[g] != BK_IDLE && bank_st_r[g] != BK_ACTIVE)
				bank_st_r[g] <= bank_st_r[g] == BK_ACTIVATING ? BK_ACTIVE : BK_IDLE;
		end
	end

	// Waiting holds a legal order back; an order illegal in settled state is dropped.
	wire tgt_settled = settled_v[bank_r];
	wire tgt_idle = idle_v[bank_r];
	wire tgt_active = bank_st_r[bank_r] == BK_ACTIVE;
	wire in_sr = pwr_r == PW_SR;
	wire in_pd = pwr_r == PW_PD || pwr_r == PW_SRPD;
	wire dev_op = ab_eff || op_r == OP_MRW || op_r == OP_SRE || op_r == OP_PDE;

	always_comb
	begin
		wait_c = blk_tmr_r != 8'h00;
		if (dev_op)
			wait_c = wait_c || !all_settled || burst_tmr_r != 8'h00;
		else if (is_rw)
			wait_c = wait_c || !tgt_settled || burst_tmr_r != 8'h00;
		else if (bank_op)
			wait_c = wait_c || !tgt_settled;
		case (op_r)
			OP_ACT: ok_c = !in_sr && tgt_idle;
			OP_RD, OP_WR, OP_MWR: ok_c = !in_sr && tgt_active;
			OP_PRE: ok_c = !in_sr;
			OP_REF: ok_c = !in_sr && (ab_r ? all_idle : tgt_idle);
			OP_MRW: ok_c = all_idle;
			OP_MRR, OP_MPC, OP_MPC_NC: ok_c = 1'b1;
			OP_SRE: ok_c = !in_sr && all_idle;
			OP_SRX, OP_PDE: ok_c = in_sr || (op_r == OP_PDE && pwr_r == PW_ACTIVE);
			OP_PDX: ok_c = 1'b1;
			default: ok_c = 1'b0;
		endcase
		ok_c = ok_c && (in_pd ? op_r == OP_PDX : op_r != OP_PDX);
	end

	// Command words: first cycle with chip select high, second with it low.
	wire [9:0] col = addr_r[9:0];
	wire [7:0] colm = {col[8:4], (op_r == OP_WR || op_r == OP_MWR) ? 2'h0 : col[3:2], 1'b0};
	wire [6:0] rw2 = {1'b0, ap_r, col[9], 1'b0, bank_r};
	wire [6:0] cas1 = {1'b1, colm[7], `CA_CAS1};
	wire [6:0] cas2 = {1'b0, colm[6:1]};

	always_comb
	begin
		seq_w[0] = 7'h00;
		seq_w[1] = {1'b0, 3'h0, bank_r};
		seq_w[2] = cas1;
		seq_w[3] = cas2;
		last_c = 2'h3;
		case (op_r)
			OP_ACT:
			begin
				seq_w[0] = {1'b1, addr_r[15:12], `CA_ACT1};
				seq_w[1] = {1'b0, addr_r[11:10], 1'b0, bank_r};
				seq_w[2] = {1'b1, addr_r[9:6], `CA_ACT2};
				seq_w[3] = {1'b0, addr_r[5:0]};
			end
			OP_RD:
			begin
				seq_w[0] = {1'b1, bl_pin, `CA_RD1};
				seq_w[1] = rw2;
			end
			OP_WR:
			begin
				seq_w[0] = {1'b1, bl_pin, `CA_WR1};
				seq_w[1] = rw2;
			end
			OP_MWR:
			begin
				seq_w[0] = {1'b1, 1'b0, `CA_MWR1};
				seq_w[1] = rw2;
			end
			OP_MRW:
			begin
				seq_w[0] = {1'b1, addr_r[15], `CA_MRW1};
				seq_w[1] = {1'b0, addr_r[5:0]};
				seq_w[2] = {1'b1, addr_r[14], `CA_MRW2};
				seq_w[3] = {1'b0, addr_r[13:8]};
			end
			OP_MRR:
			begin
				seq_w[0] = {1'b1, 1'b0, `CA_MRR1};
				seq_w[1] = {1'b0, addr_r[5:0]};
			end
			OP_MPC, OP_MPC_NC:
			begin
				seq_w[0] = {1'b1, addr_r[6], `CA_MPC1};
				seq_w[1] = {1'b0, addr_r[5:0]};
				last_c = op_r == OP_MPC ? 2'h3 : 2'h1;
			end
			OP_PRE:
			begin
				seq_w[0] = {1'b1, ab_r, `CA_PRE1};
				last_c = 2'h1;
			end
			OP_REF:
			begin
				seq_w[0] = {1'b1, ab_r, `CA_REF1};
				last_c = 2'h1;
			end
			OP_SRE, OP_SRX:
			begin
				seq_w[0] = {1'b1, 1'b0, op_r == OP_SRE ? `CA_SRE1 : `CA_SRX1};
				seq_w[1] = 7'h00;
				last_c = 2'h1;
			end
			default: last_c = 2'h1;
		endcase
	end

	// Sequencer.
	always_comb
	begin
		st_nxt = st_r;
		step_nxt = step_r;
		cnt_nxt = cnt_r;
		pwr_nxt = pwr_r;
		cke_nxt = cke_r;
		drop_c = 1'b0;
		done_c = 1'b0;
		case (st_r)
			ST_IDLE:
				if (pend_r && !wait_c)
				begin
					drop_c = !ok_c;
					if (ok_c)
						st_nxt = (op_r == OP_PDE || op_r == OP_PDX) ? ST_CKE : ST_ISSUE;
					step_nxt = 2'h0;
				end
			ST_ISSUE:
			begin
				step_nxt = step_r + 2'h1;
				if (go && op_r == OP_SRE)
					pwr_nxt = PW_SR;
				if (go && op_r == OP_SRX)
					pwr_nxt = PW_ACTIVE;
				if (step_r == last_c)
				begin
					st_nxt = op_r == OP_MPC_NC ? ST_GAP : ST_IDLE;
					cnt_nxt = 8'(`MPC_GAP_CYC);
					done_c = op_r != OP_MPC_NC;
				end
			end
			ST_GAP:
			begin
				cnt_nxt = cnt_r - 8'h01;
				done_c = cnt_r == 8'h01;
				st_nxt = done_c ? ST_IDLE : ST_GAP;
			end
			ST_CKE:
			begin
				cke_nxt = op_r == OP_PDX;
				if (op_r == OP_PDE)
					pwr_nxt = in_sr ? PW_SRPD : PW_PD;
				else
					pwr_nxt = pwr_r == PW_SRPD ? PW_SR : PW_ACTIVE;
				cnt_nxt = 8'(`T_XP_CYC);
				st_nxt = op_r == OP_PDX ? ST_XP : ST_IDLE;
				done_c = op_r == OP_PDE;
			end
			ST_XP:
			begin
				cnt_nxt = cnt_r - 8'h01;
				done_c = cnt_r == 8'h01;
				st_nxt = done_c ? ST_IDLE : ST_XP;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	wire [7:0] blk_set = op_r == OP_REF ? (ab_r ? 8'(`T_RFCAB_CYC) : 8'(`T_RFCPB_CYC)) :
		op_r == OP_MRW ? 8'(`T_MRW_CYC) : 8'(`T_MRR_CYC);
	wire blk_hit = go && (op_r == OP_REF || op_r == OP_MRW || op_r == OP_MRR);
	// Pins show deselect outside command words, so the clock enable edge sees none.
	wire [6:0] pin_nxt = st_r == ST_ISSUE ? seq_w[step_r] : 7'h00;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= ST_IDLE;
			step_r <= 2'h0;
			cnt_r <= 8'h00;
			pwr_r <= PW_ACTIVE;
			pd_act_r <= 1'b0;
			cke_r <= 1'b1;
			cs_r <= 1'b0;
			ca_r <= 6'h00;
			blk_tmr_r <= 8'h00;
			burst_tmr_r <= 8'h00;
		end
		else
		begin
			st_r <= st_nxt;
			step_r <= step_nxt;
			cnt_r <= cnt_nxt;
			pwr_r <= pwr_nxt;
			cke_r <= cke_nxt;
			{cs_r, ca_r} <= pin_nxt;
			if (st_r == ST_CKE && op_r == OP_PDE)
				pd_act_r <= !all_idle;
			blk_tmr_r <= blk_hit ? blk_set : blk_tmr_r - 8'(blk_tmr_r != 8'h00);
			burst_tmr_r <= (go && is_rw) ? burst_c : burst_tmr_r - 8'(burst_tmr_r != 8'h00);
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	cke_des_a: assert property ($changed(dram_cke) |-> !dram_cs)
		else $error("clock enable changed with a command on the bus");
	two_part_a: assert property (dram_cs |=> !dram_cs)
		else $error("first command cycle not followed by second");
	cke_high_a: assert property (dram_cs |-> dram_cke)
		else $error("command issued with clock enable low");
	mwr_bl_a: assert property (dram_cs && dram_ca[4:0] == `CA_MWR1 |-> !dram_ca[5])
		else $error("masked write with burst bit high");
	cas_follow_a: assert property (dram_cs && dram_ca[4:0] == `CA_RD1 |->
		##2 dram_cs && dram_ca[4:0] == `CA_CAS1)
		else $error("read first part not followed by column part");
	act_pair_a: assert property (dram_cs && dram_ca[1:0] == `CA_ACT1 |->
		##2 dram_cs && dram_ca[1:0] == `CA_ACT2)
		else $error("activate second part missing");
	mrw_pair_a: assert property (dram_cs && dram_ca[4:0] == `CA_MRW1 |->
		##2 dram_cs && dram_ca[4:0] == `CA_MRW2)
		else $error("mode write second part missing");
	mpc_gap_a: assert property (dram_cs && dram_ca[4:0] == `CA_MPC1 && op_r == OP_MPC_NC |=>
		!dram_cs [*3])
		else $error("no two deselects after multipurpose command");
	wr_col_a: assert property (dram_cs && dram_ca[4:0] == `CA_WR1 |-> ##3 dram_ca[1:0] == 2'h0)
		else $error("write column bits 3:2 not low");
	xp_wait_a: assert property ($rose(dram_cke) |-> !dram_cs [*3])
		else $error("command too soon after power-down exit");
	sr_only_a: assert property (go && pwr_r == PW_SR |->
		op_r inside {OP_MRR, OP_MRW, OP_MPC, OP_MPC_NC, OP_SRX})
		else $error("disallowed command in self refresh");
	turn_a: assert property (go && is_rw |-> $past(burst_tmr_r) == 8'h00)
		else $error("read/write before earlier burst ended");

	act_cov: cover property (dram_cs && dram_ca[1:0] == `CA_ACT1 ##2 dram_cs);
	pd_cov: cover property ($fell(dram_cke) ##[1:50] $rose(dram_cke));
	sr_cov: cover property (pwr_r == PW_SR ##[1:100] pwr_r == PW_SRPD);
	gap_cov: cover property (st_r == ST_GAP ##2 st_r == ST_IDLE);

endmodule

`default_nettype wire
